// ### rtl/dmm_defines.svh
`ifndef DMM_DEFINES_SVH
`define DMM_DEFINES_SVH

// clock and time base
`define DMM_CLK_PERIOD_NS 100
`define DMM_TENTH_NS 100000000
`define DMM_TENTH_MS 100
`define DMM_HOUR_S 3600

// capacitor measurement status codes
`define DMM_MEAS_NONE 4'h0
`define DMM_MEAS_ARMED 4'h1
`define DMM_MEAS_BUSY 4'h2
`define DMM_MEAS_DONE 4'h3
`define DMM_MEAS_FORCED 4'h8
`define DMM_MEAS_ERROR 4'h9
`define DMM_DC_INJECT_MS 1000
`define DMM_CAP_LIMIT_PCT 8'h55

// life status word bit positions
`define DMM_LIFE_CTRL_CAP 0
`define DMM_LIFE_MAIN_CAP 1
`define DMM_LIFE_FAN 2
`define DMM_LIFE_INRUSH 3
`define DMM_NUM_FANS 2

// maintenance timer, counts of 100 h
`define DMM_HOURS_MAX 14'h270e
`define DMM_HOURS_OFF 14'h270f
`define DMM_HOURS_PER_UNIT 7'h64

// current monitor pulse train
`define DMM_START_MS 1000
`define DMM_CYCLE_MS 20000
`define DMM_INV_HI_MS 3500
`define DMM_INV_LO_MS 16500
`define DMM_CUR_MIN_T 8'h05
`define DMM_CUR_MAX_T 8'h5a
`define DMM_MNT_MIN_T 8'h14
`define DMM_MNT_MAX_T 8'h5a

// terminal function codes
`define DMM_FN_LIFE 8'h5a
`define DMM_FN_CURRENT 8'h5d
`define DMM_FN_MAINT 8'h5f
`define DMM_FN_NEG_OFS 8'h64
`define DMM_NUM_TERMS 3

`endif

// ### rtl/dmm_pkg.sv
package dmm_pkg;

  typedef enum logic [1:0] {
    CM_IDLE,
    CM_INJECT,
    CM_WAIT
  } dmm_cap_state_t;

  typedef enum logic [2:0] {
    CP_IDLE,
    CP_MASK,
    CP_START,
    CP_CUR,
    CP_MAINT,
    CP_END,
    CP_INV_HI,
    CP_INV_LO
  } dmm_pulse_state_t;

endpackage

// ### rtl/dmm_monitor.sv
// Operation
// - measured main capacitor at or below 85% sets life bit 1 and life alarm.
// - software arms measurement with code 1; measurement starts at supply power-off.
// - codes 2, 3, 8, 9 are status only; software writes of them are rejected.
// - start, shutoff, power return or trip during DC injection gives forced end or error.
// - power back after injection leaves code 2; software must rearm.
// - armed measurement injects DC into the motor for one second at power-off.
// - fan at half speed or less sets fan fault, life bit 2, life alarm.
// - any single slow fan raises the fan fault indication.
// - powered time accumulates, saved each hour, shown in 100 hour units.
// - only whole hours count; a partial hour at power-off is dropped.
// - hour count saturates at 9998 and never wraps.
// - writing zero to the hour count clears accumulated time; other values ignored.
// - hour count reaching setpoint raises maintenance alarm; setpoint 9999 disables it.
// - current monitor codes 93 or 193 work on terminals 0 and 1 only.
// - at constant speed the current pulse train repeats in 20 second cycles.
// - after reaching constant speed, data is masked for a programmable 0 to 20 s.
// - one second high start pulse; current averaged over a 0.1 to 1 s window.
// - average current is scaled against a 0 to 500 A reference as 100%.
// - low pulse lasts avg/ref times 5 s, clamped to 0.5 s and 9 s.
// - high pulse lasts hours*100/40000 h times 5 s, clamped 2 to 9 s.
// - speed change during start pulse gives 3.5 s high then 16.5 s low.
// - life alarm is high whenever any of the four life bits is set.
`include "dmm_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module dmm_monitor #(
  parameter int CYC_PER_TENTH = `DMM_TENTH_NS / `DMM_CLK_PERIOD_NS,
  parameter int TENTHS_PER_HOUR = `DMM_HOUR_S * 10
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // supply and drive state
  input wire logic supply_on_i,
  input wire logic accel_decel_i,
  input wire logic start_cmd_i,
  input wire logic output_shutoff_input_i,
  input wire logic trip_i,
  input wire logic [9:0] out_current_i,
  // capacitor measurement
  input wire logic meas_ctrl_wr_i,
  input wire logic [3:0] meas_ctrl_wdata_i,
  input wire logic cap_meas_done_i,
  input wire logic cap_meas_error_i,
  input wire logic [7:0] cap_meas_value_i,
  output logic [3:0] cap_measure_control_o,
  output logic [7:0] main_cap_life_value_o,
  output logic dc_inject_o,
  // life status
  input wire logic ctrl_cap_life_i,
  input wire logic inrush_life_i,
  input wire logic [`DMM_NUM_FANS-1:0] fan_speed_low_i,
  output logic [3:0] life_status_word_o,
  output logic life_alarm_out_o,
  output logic fan_fault_indication_o,
  // maintenance timer
  input wire logic hours_wr_i,
  input wire logic [13:0] hours_wdata_i,
  input wire logic [13:0] hours_alarm_setpoint_i,
  output logic [13:0] energized_hours_count_o,
  output logic nvm_save_o,
  output logic maint_hours_alarm_out_o,
  output logic maint_due_indication_o,
  // current monitor settings
  input wire logic [3:0] current_avg_window_i,
  input wire logic [7:0] transient_mask_time_i,
  input wire logic [9:0] current_reference_i,
  output logic current_avg_pulse_out_o,
  // output terminals, 8 bit function code per terminal
  input wire logic [8*`DMM_NUM_TERMS-1:0] output_terminal_select_i,
  output logic [`DMM_NUM_TERMS-1:0] term_out_o
);

  localparam logic [7:0] INJ_T = 8'(`DMM_DC_INJECT_MS / `DMM_TENTH_MS);
  localparam logic [7:0] START_T = 8'(`DMM_START_MS / `DMM_TENTH_MS);
  localparam logic [7:0] CYCLE_T = 8'(`DMM_CYCLE_MS / `DMM_TENTH_MS);
  localparam logic [7:0] INV_HI_T = 8'(`DMM_INV_HI_MS / `DMM_TENTH_MS);
  localparam logic [7:0] INV_LO_T = 8'(`DMM_INV_LO_MS / `DMM_TENTH_MS);

  logic [1:0] rst_sync_ff;
  logic rst_sync_n;
  logic [31:0] presc_ff;
  logic tick;

  // reset release through two stages
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_sync_n = rst_sync_ff[1];

  // tenth second time base shared by every timed function
  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      presc_ff <= 32'h0;
    end else if (presc_ff == 32'(CYC_PER_TENTH - 1)) begin
      presc_ff <= 32'h0;
    end else begin
      presc_ff <= presc_ff + 32'h1;
    end
  end
  assign tick = (presc_ff == 32'(CYC_PER_TENTH - 1));

  // capacitor measurement; the logic itself stays powered, so the code survives supply loss
  dmm_pkg::dmm_cap_state_t cm_state_ff;
  logic [3:0] meas_code_ff;
  logic [7:0] inj_cnt_ff;
  logic [7:0] cap_value_ff;
  logic cap_low_ff;
  logic supply_q_ff;
  logic power_off;
  logic power_on;

  assign power_off = supply_q_ff & ~supply_on_i;
  assign power_on = ~supply_q_ff & supply_on_i;

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      supply_q_ff <= 1'b0;
    end else begin
      supply_q_ff <= supply_on_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cm_state_ff <= dmm_pkg::CM_IDLE;
      meas_code_ff <= `DMM_MEAS_NONE;
      inj_cnt_ff <= 8'h0;
      cap_value_ff <= 8'h0;
      cap_low_ff <= 1'b0;
    end else begin
      unique case (cm_state_ff)
        dmm_pkg::CM_IDLE: begin
          if (power_off && meas_code_ff == `DMM_MEAS_ARMED) begin
            // a fault present at power-off leaves the measurement armed
            if (!(trip_i || output_shutoff_input_i || start_cmd_i)) begin
              meas_code_ff <= `DMM_MEAS_BUSY;
              cm_state_ff <= dmm_pkg::CM_INJECT;
              inj_cnt_ff <= 8'h0;
            end
          end else if (meas_ctrl_wr_i && (meas_ctrl_wdata_i == `DMM_MEAS_NONE ||
                       meas_ctrl_wdata_i == `DMM_MEAS_ARMED)) begin
            meas_code_ff <= meas_ctrl_wdata_i;
          end
        end
        dmm_pkg::CM_INJECT: begin
          if (trip_i) begin
            meas_code_ff <= `DMM_MEAS_ERROR;
            cm_state_ff <= dmm_pkg::CM_IDLE;
          end else if (start_cmd_i || output_shutoff_input_i || power_on) begin
            meas_code_ff <= `DMM_MEAS_FORCED;
            cm_state_ff <= dmm_pkg::CM_IDLE;
          end else if (tick) begin
            inj_cnt_ff <= inj_cnt_ff + 8'h1;
            if (inj_cnt_ff == INJ_T - 8'h1) begin
              cm_state_ff <= dmm_pkg::CM_WAIT;
            end
          end
        end
        dmm_pkg::CM_WAIT: begin
          if (cap_meas_done_i) begin
            cm_state_ff <= dmm_pkg::CM_IDLE;
            if (cap_meas_error_i) begin
              meas_code_ff <= `DMM_MEAS_ERROR;
            end else begin
              meas_code_ff <= `DMM_MEAS_DONE;
              cap_value_ff <= cap_meas_value_i;
              cap_low_ff <= (cap_meas_value_i <= `DMM_CAP_LIMIT_PCT);
            end
          end else if (power_on) begin
            cm_state_ff <= dmm_pkg::CM_IDLE;
          end
        end
        default: begin
          cm_state_ff <= dmm_pkg::CM_IDLE;
        end
      endcase
    end
  end

  assign cap_measure_control_o = meas_code_ff;
  assign main_cap_life_value_o = cap_value_ff;
  assign dc_inject_o = (cm_state_ff == dmm_pkg::CM_INJECT);

  // life status word
  logic [3:0] life_word_ff;
  logic fan_low_any;

  assign fan_low_any = |fan_speed_low_i;

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      life_word_ff <= 4'h0;
    end else begin
      life_word_ff[`DMM_LIFE_CTRL_CAP] <= ctrl_cap_life_i;
      life_word_ff[`DMM_LIFE_MAIN_CAP] <= cap_low_ff;
      life_word_ff[`DMM_LIFE_FAN] <= fan_low_any;
      life_word_ff[`DMM_LIFE_INRUSH] <= inrush_life_i;
    end
  end

  assign life_status_word_o = life_word_ff;
  assign fan_fault_indication_o = life_word_ff[`DMM_LIFE_FAN];
  assign life_alarm_out_o = |life_word_ff;

  // energization timer
  logic [31:0] hour_tenths_ff;
  logic [6:0] hours_sub_ff;
  logic [13:0] hours_ff;
  logic hour_done;
  logic save_ff;
  logic maint_alarm_ff;

  assign hour_done = supply_on_i && tick && (hour_tenths_ff == 32'(TENTHS_PER_HOUR - 1));

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      hour_tenths_ff <= 32'h0;
      hours_sub_ff <= 7'h0;
      hours_ff <= 14'h0;
      save_ff <= 1'b0;
    end else begin
      save_ff <= hour_done;
      if (hours_wr_i && hours_wdata_i == 14'h0) begin
        hour_tenths_ff <= 32'h0;
        hours_sub_ff <= 7'h0;
        hours_ff <= 14'h0;
      end else if (!supply_on_i) begin
        hour_tenths_ff <= 32'h0;
      end else if (tick) begin
        if (hour_done) begin
          hour_tenths_ff <= 32'h0;
          if (hours_sub_ff == `DMM_HOURS_PER_UNIT - 7'h1) begin
            hours_sub_ff <= 7'h0;
            if (hours_ff != `DMM_HOURS_MAX) begin
              hours_ff <= hours_ff + 14'h1;
            end
          end else begin
            hours_sub_ff <= hours_sub_ff + 7'h1;
          end
        end else begin
          hour_tenths_ff <= hour_tenths_ff + 32'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      maint_alarm_ff <= 1'b0;
    end else begin
      maint_alarm_ff <= (hours_alarm_setpoint_i != `DMM_HOURS_OFF) &&
                        (hours_ff >= hours_alarm_setpoint_i);
    end
  end

  assign energized_hours_count_o = hours_ff;
  assign nvm_save_o = save_ff;
  assign maint_hours_alarm_out_o = maint_alarm_ff;
  assign maint_due_indication_o = maint_alarm_ff;

  // current average pulse train, timed in tenths of a second
  dmm_pkg::dmm_pulse_state_t cp_state_ff;
  logic [7:0] ph_ff;
  logic [15:0] cur_sum_ff;
  logic [3:0] cur_n_ff;
  logic [7:0] cur_len_ff;
  logic [7:0] mnt_len_ff;
  logic accel_q_ff;
  logic pulse_ff;
  logic [7:0] cur_len_calc;
  logic [7:0] mnt_len_calc;
  logic [31:0] num32;
  logic [31:0] den32;

  // low time in tenths = avg/ref * 50, clamped at 10% and 180%
  always_comb begin
    num32 = 32'(cur_sum_ff) * 32'd10;
    den32 = 32'(cur_n_ff) * 32'(current_reference_i);
    if (den32 == 32'h0 || num32 > den32 * 32'd18) begin
      cur_len_calc = `DMM_CUR_MAX_T;
    end else if (num32 < den32) begin
      cur_len_calc = `DMM_CUR_MIN_T;
    end else begin
      cur_len_calc = 8'((num32 * 32'd5) / den32);
    end
  end

  // hours*100/40000 h * 50 tenths reduces to count/8
  always_comb begin
    if (hours_ff[13:3] < 11'(`DMM_MNT_MIN_T)) begin
      mnt_len_calc = `DMM_MNT_MIN_T;
    end else if (hours_ff[13:3] > 11'(`DMM_MNT_MAX_T)) begin
      mnt_len_calc = `DMM_MNT_MAX_T;
    end else begin
      mnt_len_calc = hours_ff[10:3];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      accel_q_ff <= 1'b1;
    end else begin
      accel_q_ff <= accel_decel_i;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      cp_state_ff <= dmm_pkg::CP_IDLE;
      ph_ff <= 8'h0;
      cur_sum_ff <= 16'h0;
      cur_n_ff <= 4'h0;
      cur_len_ff <= `DMM_CUR_MIN_T;
      mnt_len_ff <= `DMM_MNT_MIN_T;
    end else begin
      unique case (cp_state_ff)
        dmm_pkg::CP_IDLE: begin
          if (accel_q_ff && !accel_decel_i) begin
            cp_state_ff <= dmm_pkg::CP_MASK;
            ph_ff <= 8'h0;
          end
        end
        dmm_pkg::CP_MASK: begin
          if (accel_decel_i) begin
            cp_state_ff <= dmm_pkg::CP_IDLE;
          end else if (tick) begin
            if (ph_ff >= transient_mask_time_i) begin
              cp_state_ff <= dmm_pkg::CP_START;
              ph_ff <= 8'h0;
              cur_sum_ff <= 16'h0;
              cur_n_ff <= 4'h0;
            end else begin
              ph_ff <= ph_ff + 8'h1;
            end
          end
        end
        dmm_pkg::CP_START: begin
          if (accel_decel_i) begin
            cp_state_ff <= dmm_pkg::CP_INV_HI;
          end else if (tick) begin
            ph_ff <= ph_ff + 8'h1;
            if (ph_ff < 8'(current_avg_window_i)) begin
              cur_sum_ff <= cur_sum_ff + 16'(out_current_i);
              cur_n_ff <= cur_n_ff + 4'h1;
            end
            if (ph_ff == START_T - 8'h1) begin
              cp_state_ff <= dmm_pkg::CP_CUR;
              ph_ff <= 8'h0;
              cur_len_ff <= cur_len_calc;
              mnt_len_ff <= mnt_len_calc;
            end
          end
        end
        dmm_pkg::CP_CUR: begin
          if (tick) begin
            ph_ff <= ph_ff + 8'h1;
            if (ph_ff == cur_len_ff - 8'h1) begin
              cp_state_ff <= dmm_pkg::CP_MAINT;
              ph_ff <= 8'h0;
            end
          end
        end
        dmm_pkg::CP_MAINT: begin
          if (tick) begin
            ph_ff <= ph_ff + 8'h1;
            if (ph_ff == mnt_len_ff - 8'h1) begin
              cp_state_ff <= dmm_pkg::CP_END;
              ph_ff <= 8'h0;
            end
          end
        end
        dmm_pkg::CP_INV_HI: begin
          if (tick) begin
            ph_ff <= ph_ff + 8'h1;
            if (ph_ff == INV_HI_T - 8'h1) begin
              cp_state_ff <= dmm_pkg::CP_INV_LO;
              ph_ff <= 8'h0;
            end
          end
        end
        dmm_pkg::CP_END, dmm_pkg::CP_INV_LO: begin
          if (tick) begin
            ph_ff <= ph_ff + 8'h1;
            // the end gap fills the cycle out to exactly 20 s
            if ((cp_state_ff == dmm_pkg::CP_END &&
                 ph_ff == CYCLE_T - START_T - cur_len_ff - mnt_len_ff - 8'h1) ||
                (cp_state_ff == dmm_pkg::CP_INV_LO && ph_ff == INV_LO_T - 8'h1)) begin
              ph_ff <= 8'h0;
              cur_sum_ff <= 16'h0;
              cur_n_ff <= 4'h0;
              cp_state_ff <= accel_decel_i ? dmm_pkg::CP_IDLE : dmm_pkg::CP_START;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pulse_ff <= 1'b0;
    end else begin
      pulse_ff <= (cp_state_ff == dmm_pkg::CP_START) || (cp_state_ff == dmm_pkg::CP_MAINT) ||
                  (cp_state_ff == dmm_pkg::CP_INV_HI);
    end
  end
  assign current_avg_pulse_out_o = pulse_ff;

  // output terminal routing, code plus 100 inverts the level
  genvar gi;
  generate
    for (gi = 0; gi < `DMM_NUM_TERMS; gi++) begin : g_term
      logic [7:0] sel;
      logic [7:0] fn;
      logic lvl;
      logic term_ff;
      assign sel = output_terminal_select_i[8*gi +: 8];
      assign fn = (sel >= `DMM_FN_NEG_OFS) ? sel - `DMM_FN_NEG_OFS : sel;
      always_comb begin
        lvl = 1'b0;
        if (fn == `DMM_FN_LIFE) begin
          lvl = life_alarm_out_o;
        end else if (fn == `DMM_FN_MAINT) begin
          lvl = maint_alarm_ff;
        end else if (fn == `DMM_FN_CURRENT && gi < 2) begin
          lvl = pulse_ff;
        end
      end
      always_ff @(posedge ref_clk_i or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
          term_ff <= 1'b0;
        end else begin
          term_ff <= (sel >= `DMM_FN_NEG_OFS) ? ~lvl : lvl;
        end
      end
      assign term_out_o[gi] = term_ff;
    end
  endgenerate

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_sync_n);

  property p_cap_low;
    cm_state_ff == dmm_pkg::CM_WAIT && cap_meas_done_i && !cap_meas_error_i &&
      cap_meas_value_i <= `DMM_CAP_LIMIT_PCT |-> ##2 life_status_word_o[1] && life_alarm_out_o;
  endproperty
  a_cap_low: assert property (p_cap_low) else $error("low capacitor not flagged");
  property p_no_status_write;
    meas_ctrl_wr_i && meas_ctrl_wdata_i > `DMM_MEAS_ARMED && cm_state_ff == dmm_pkg::CM_IDLE &&
      !power_off |=> $stable(cap_measure_control_o);
  endproperty
  a_no_status_write: assert property (p_no_status_write) else $error("status code written");
  property p_abort;
    dc_inject_o && (start_cmd_i || output_shutoff_input_i) && !trip_i |=>
      cap_measure_control_o == `DMM_MEAS_FORCED && !dc_inject_o;
  endproperty
  a_abort: assert property (p_abort) else $error("measurement abort missed");
  property p_inject;
    $rose(dc_inject_o) |-> cap_measure_control_o == `DMM_MEAS_BUSY && $past(power_off);
  endproperty
  a_inject: assert property (p_inject) else $error("injection without power-off");
  property p_fan;
    fan_low_any |=> fan_fault_indication_o && life_status_word_o[2];
  endproperty
  a_fan: assert property (p_fan) else $error("fan fault missing");
  property p_sat;
    energized_hours_count_o <= `DMM_HOURS_MAX;
  endproperty
  a_sat: assert property (p_sat) else $error("hour count above limit");
  property p_clear;
    hours_wr_i && hours_wdata_i == 14'h0 |=> energized_hours_count_o == 14'h0;
  endproperty
  a_clear: assert property (p_clear) else $error("hour clear failed");
  property p_maint;
    ##1 maint_hours_alarm_out_o == ($past(hours_alarm_setpoint_i) != `DMM_HOURS_OFF &&
      $past(energized_hours_count_o) >= $past(hours_alarm_setpoint_i));
  endproperty
  a_maint: assert property (p_maint) else $error("maintenance alarm wrong");
  property p_invalid;
    cp_state_ff == dmm_pkg::CP_START && accel_decel_i |=> cp_state_ff == dmm_pkg::CP_INV_HI ##1 pulse_ff;
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid start not taken");
  property p_lens;
    cp_state_ff == dmm_pkg::CP_CUR |-> cur_len_ff >= `DMM_CUR_MIN_T && cur_len_ff <= `DMM_CUR_MAX_T &&
      mnt_len_ff >= `DMM_MNT_MIN_T && mnt_len_ff <= `DMM_MNT_MAX_T;
  endproperty
  a_lens: assert property (p_lens) else $error("pulse length out of range");
  property p_relay;
    output_terminal_select_i[23:16] == `DMM_FN_CURRENT |=> !term_out_o[2];
  endproperty
  a_relay: assert property (p_relay) else $error("relay carries current monitor");

  c_meas_done: cover property (cm_state_ff == dmm_pkg::CM_WAIT && cap_meas_done_i);
  c_cycle: cover property (cp_state_ff == dmm_pkg::CP_END ##1 cp_state_ff == dmm_pkg::CP_START);
  c_invalid: cover property (cp_state_ff == dmm_pkg::CP_INV_LO);
  c_maint: cover property ($rose(maint_hours_alarm_out_o));

endmodule // dmm_monitor

`default_nettype wire

// ### test/dmm_plc_input.sv
`timescale 1ns/1ps
`default_nettype none
// controller input card: records the widths, in clocks, of the first pulses after the first rise
module dmm_plc_input (
  // sampled pulse line
  input wire logic clk_i,
  input wire logic pulse_i
);
  int run = 0;
  int n_hi = 0;
  int hi_w [0:1];
  int lo_w = 0;
  logic last = 1'b0;
  always @(posedge clk_i) begin
    if (pulse_i !== last) begin
      if (last && n_hi < 2) begin
        hi_w[n_hi] = run;
        n_hi++;
      end else if (!last && n_hi == 1) begin
        lo_w = run;
      end
      run = 0;
    end
    run++;
    last = pulse_i;
  end
endmodule // dmm_plc_input
`default_nettype wire

// ### test/drive_maintenance_monitor_tb.sv
`include "dmm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module drive_maintenance_monitor_tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic supply_on_i = 1'b1;
  logic accel_decel_i = 1'b0;
  logic start_cmd_i = 1'b0;
  logic output_shutoff_input_i = 1'b0;
  logic trip_i = 1'b0;
  logic [9:0] out_current_i = 10'h00f;
  logic meas_ctrl_wr_i = 1'b0;
  logic [3:0] meas_ctrl_wdata_i = 4'h0;
  logic cap_meas_done_i = 1'b0;
  logic cap_meas_error_i = 1'b0;
  logic [7:0] cap_meas_value_i = 8'h00;
  logic ctrl_cap_life_i = 1'b0;
  logic inrush_life_i = 1'b0;
  logic [1:0] fan_speed_low_i = 2'h0;
  logic hours_wr_i = 1'b0;
  logic [13:0] hours_wdata_i = 14'h0000;
  logic [13:0] hours_alarm_setpoint_i = `DMM_HOURS_OFF;
  logic [3:0] current_avg_window_i = 4'ha;
  logic [7:0] transient_mask_time_i = 8'h00;
  logic [9:0] current_reference_i = 10'h00a;
  // terminal 2 is the relay and must not take the current code
  logic [23:0] output_terminal_select_i = 24'h5dc35d;
  logic [3:0] cap_measure_control_o;
  logic [7:0] main_cap_life_value_o;
  logic [3:0] life_status_word_o;
  logic [13:0] energized_hours_count_o;
  logic [2:0] term_out_o;
  logic dc_inject_o, life_alarm_out_o, fan_fault_indication_o, nvm_save_o;
  logic maint_hours_alarm_out_o, maint_due_indication_o, current_avg_pulse_out_o;
  int miscompares = 0;
  int comparisons = 0;
  int cycles = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  // short time base keeps one hundred hours near 1200 clocks
  dmm_monitor #(.CYC_PER_TENTH(4), .TENTHS_PER_HOUR(3)) i_dut (.ref_clk_i, .rst_n_i, .supply_on_i,
    .accel_decel_i, .start_cmd_i, .output_shutoff_input_i, .trip_i, .out_current_i, .meas_ctrl_wr_i,
    .meas_ctrl_wdata_i, .cap_meas_done_i, .cap_meas_error_i, .cap_meas_value_i, .cap_measure_control_o,
    .main_cap_life_value_o, .dc_inject_o, .ctrl_cap_life_i, .inrush_life_i, .fan_speed_low_i,
    .life_status_word_o, .life_alarm_out_o, .fan_fault_indication_o, .hours_wr_i, .hours_wdata_i,
    .hours_alarm_setpoint_i, .energized_hours_count_o, .nvm_save_o, .maint_hours_alarm_out_o,
    .maint_due_indication_o, .current_avg_window_i, .transient_mask_time_i, .current_reference_i,
    .current_avg_pulse_out_o, .output_terminal_select_i, .term_out_o);
  dmm_plc_input i_plc (.clk_i(ref_clk_i), .pulse_i(term_out_o[0]));

  task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic chk_w(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      miscompares++;
      $display("[ERR] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask
  task automatic wr_meas(input logic [3:0] c);
    meas_ctrl_wdata_i = c;
    meas_ctrl_wr_i = 1'b1;
    cyc(1);
    meas_ctrl_wr_i = 1'b0;
  endtask
  task automatic wr_hours(input logic [13:0] v);
    hours_wdata_i = v;
    hours_wr_i = 1'b1;
    cyc(1);
    hours_wr_i = 1'b0;
  endtask
  task automatic print_verdict;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // 15 A against 10 A gives 75 tenths low; zero hours gives the 2 s floor
  task automatic t_pulse;
    cyc(500);
    chk_w("start width", 40, i_plc.hi_w[0]);
    chk_w("current width", 300, i_plc.lo_w);
    chk_w("hours width", 80, i_plc.hi_w[1]);
    chk("relay term", 14'h0000, {13'h0, term_out_o[2]});
    $display("test pulse done");
  endtask
  task automatic t_cap;
    wr_meas(4'h3);
    chk("status write", 14'h0000, {10'h0, cap_measure_control_o});
    wr_meas(4'h1);
    chk("arm", 14'h0001, {10'h0, cap_measure_control_o});
    supply_on_i = 1'b0;
    cyc(1);
    chk("busy", 14'h0002, {10'h0, cap_measure_control_o});
    cyc(35);
    chk("inject", 14'h0001, {13'h0, dc_inject_o});
    cyc(9);
    chk("inject end", 14'h0000, {13'h0, dc_inject_o});
    cap_meas_value_i = 8'h55;
    cap_meas_done_i = 1'b1;
    cyc(1);
    cap_meas_done_i = 1'b0;
    chk("done", 14'h0003, {10'h0, cap_measure_control_o});
    chk("cap value", 14'h0055, {6'h0, main_cap_life_value_o});
    cyc(1);
    chk("cap life", 14'h0002, {10'h0, life_status_word_o});
    chk("life alarm", 14'h0001, {13'h0, life_alarm_out_o});
    supply_on_i = 1'b1;
    cyc(2);
    chk("kept", 14'h0003, {10'h0, cap_measure_control_o});
    wr_meas(4'h1);
    supply_on_i = 1'b0;
    cyc(5);
    trip_i = 1'b1;
    cyc(2);
    chk("trip", 14'h0009, {10'h0, cap_measure_control_o});
    trip_i = 1'b0;
    supply_on_i = 1'b1;
    wr_meas(4'h1);
    supply_on_i = 1'b0;
    cyc(3);
    output_shutoff_input_i = 1'b1;
    cyc(1);
    chk("forced", 14'h0008, {10'h0, cap_measure_control_o});
    output_shutoff_input_i = 1'b0;
    supply_on_i = 1'b1;
    wr_meas(4'h1);
    supply_on_i = 1'b0;
    cyc(45);
    supply_on_i = 1'b1;
    cyc(2);
    chk("stuck busy", 14'h0002, {10'h0, cap_measure_control_o});
    $display("test cap done");
  endtask
  task automatic t_life;
    fan_speed_low_i = 2'b10;
    cyc(3);
    chk("fan word", 14'h0006, {10'h0, life_status_word_o});
    chk("fan ind", 14'h0001, {13'h0, fan_fault_indication_o});
    ctrl_cap_life_i = 1'b1;
    inrush_life_i = 1'b1;
    output_terminal_select_i[23:16] = `DMM_FN_LIFE;
    cyc(3);
    chk("all life", 14'h000f, {10'h0, life_status_word_o});
    chk("life term", 14'h0001, {13'h0, term_out_o[2]});
    $display("test life done");
  endtask
  task automatic t_hours;
    hours_alarm_setpoint_i = 14'h0001;
    cyc(2);
    chk("no alarm", 14'h0000, {13'h0, maint_hours_alarm_out_o});
    for (int i = 0; i < 1300 && energized_hours_count_o !== 14'h0001; i++)
      cyc(1);
    chk("hours", 14'h0001, energized_hours_count_o);
    cyc(2);
    chk("alarm", 14'h0001, {13'h0, maint_hours_alarm_out_o});
    chk("due", 14'h0001, {13'h0, maint_due_indication_o});
    chk("neg term", 14'h0000, {13'h0, term_out_o[1]});
    for (int i = 0; i < 20 && nvm_save_o !== 1'b1; i++)
      cyc(1);
    chk("save", 14'h0001, {13'h0, nvm_save_o});
    cyc(1);
    chk("save end", 14'h0000, {13'h0, nvm_save_o});
    wr_hours(14'h0005);
    chk("bad clear", 14'h0001, energized_hours_count_o);
    wr_hours(14'h0000);
    cyc(2);
    chk("cleared", 14'h0000, energized_hours_count_o);
    chk("alarm off", 14'h0000, {13'h0, maint_hours_alarm_out_o});
    $display("test hours done");
  endtask
  task automatic t_inv;
    int n = 0;
    for (int i = 0; i < 1700 && !(current_avg_pulse_out_o && n > 340); i++) begin
      n = current_avg_pulse_out_o ? 0 : n + 1;
      cyc(1);
    end
    accel_decel_i = 1'b1;
    for (n = 0; n < 200 && current_avg_pulse_out_o; n++)
      cyc(1);
    accel_decel_i = 1'b0;
    chk_w("invalid high", `DMM_INV_HI_MS / `DMM_TENTH_MS * 4, n);
    for (n = 0; n < 800 && !current_avg_pulse_out_o; n++)
      cyc(1);
    chk_w("invalid low", `DMM_INV_LO_MS / `DMM_TENTH_MS * 4, n);
    $display("test invalid done");
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    // a hang would otherwise stall the run forever
    if (cycles == 6000) begin
      miscompares++;
      print_verdict;
    end
  end

  initial begin
    cyc(3);
    rst_n_i = 1'b1;
    cyc(3);
    t_pulse;
    t_cap;
    t_life;
    t_hours;
    t_inv;
    print_verdict;
  end
endmodule // drive_maintenance_monitor_tb
`default_nettype wire
